// File: cmdu_pkg.sv
/*
 * Shared constants and types of the clock mode divider unit.
 * Assumes a single reference clock that stands for the oscillator clock.
 */
package cmdu_pkg;

    // ****************************************
    // Widths, VCO model constants and reset values
    // ****************************************
    localparam int          CMDU_DIV_W     = 4;
    localparam int          CMDU_ACC_W     = 7;
    localparam int          CMDU_VCO_DIV   = 64;
    localparam int          CMDU_BASE_INC  = 16;
    localparam logic [3:0]  CMDU_RST_P     = 4'h1;
    localparam logic [3:0]  CMDU_RST_N     = 4'h1;
    localparam logic [3:0]  CMDU_RST_K     = 4'h1;

    // ****************************************
    // Mode selection
    // ****************************************
    typedef enum logic [1:0] {
        CMDU_DIRECT   = 2'h0,
        CMDU_PRESCALE = 2'h1,
        CMDU_PLL      = 2'h2,
        CMDU_BASE     = 2'h3
    } cmdu_mode_t;

    localparam cmdu_mode_t  CMDU_RST_MODE  = CMDU_DIRECT;

    typedef enum logic [1:0] {
        CMDU_ST_RUN,
        CMDU_ST_DRAIN,
        CMDU_ST_LOAD
    } cmdu_state_t;

endpackage

// File: cmdu_div.sv
/*
 * Divide-by-ratio counter for enable pulses; ratio 0 acts as 1.
 * Assumes tick_in is a one-cycle enable on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cmdu_div #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         clr,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] ratio,
    output logic              tick_out
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] top;
    logic         last;

    assign top      = (ratio == '0) ? '0 : W'(ratio - 1'b1);
    assign last     = (cnt_q >= top);
    assign tick_out = tick_in & last;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            cnt_q <= last ? '0 : W'(cnt_q + 1'b1);
        end
    end

endmodule

`default_nettype wire

// File: cmdu_top.sv
/*
 * Clock mode divider unit: derives processor and system bus clock enables
 * from the oscillator clock in one of four modes, with a safe switch sequence.
 * Assumes ref_clk is the oscillator clock and that the mode and factor
 * inputs come from logic on the same clock. The VCO is modelled as a
 * numerically controlled enable of rate n/(p*VCO_DIV) of the reference, or BASE_INC/VCO_DIV in base mode.
 */
`timescale 1ns/10ps
`default_nettype none

module cmdu_top
    import cmdu_pkg::*;
#(
    parameter int VCO_DIV  = CMDU_VCO_DIV,
    parameter int BASE_INC = CMDU_BASE_INC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire cmdu_mode_t            mode_req,
    input  wire logic [CMDU_DIV_W-1:0] p_factor,
    input  wire logic [CMDU_DIV_W-1:0] n_factor,
    input  wire logic [CMDU_DIV_W-1:0] k_factor,
    output logic                       processor_clock_en,
    output logic                       system_bus_clock_en,
    output cmdu_mode_t                 active_mode,
    output logic                       switch_busy
);

    // ****************************************
    // Working state
    // ****************************************
    cmdu_state_t           state_q;
    cmdu_mode_t            mode_q;
    logic [CMDU_DIV_W-1:0] p_q;
    logic [CMDU_DIV_W-1:0] n_q;
    logic [CMDU_DIV_W-1:0] k_q;
    logic [CMDU_ACC_W-1:0] acc_q;
    logic [CMDU_ACC_W-1:0] acc_sum;
    logic [CMDU_ACC_W-1:0] acc_inc;
    logic                  acc_step;
    logic                  vco_tick;
    logic                  p_tick;
    logic                  k_in;
    logic                  k_tick;
    logic                  load;
    logic                  out_d;
    logic                  differs;
    logic                  out_q;

    localparam logic [CMDU_ACC_W-1:0] VCO_MOD = CMDU_ACC_W'(VCO_DIV);
    localparam logic [CMDU_ACC_W-1:0] BASE_S  = CMDU_ACC_W'(BASE_INC);

    assign load    = (state_q == CMDU_ST_LOAD);
    assign differs = (mode_req != mode_q) || (p_factor != p_q) || (n_factor != n_q) || (k_factor != k_q);

    // ****************************************
    // Predivider on the oscillator clock
    // ****************************************
    cmdu_div #(.W(CMDU_DIV_W)) u_pdiv (
        .clk      (ref_clk),
        .rstn     (rstn),
        .clr      (load),
        .tick_in  (1'b1),
        .ratio    (p_q),
        .tick_out (p_tick)
    );

    // ****************************************
    // VCO model: locked rate or base rate
    // ****************************************
    assign acc_inc  = (mode_q == CMDU_BASE) ? BASE_S : CMDU_ACC_W'(n_q);
    assign acc_step = (mode_q == CMDU_BASE) ? 1'b1 : p_tick;
    assign acc_sum  = CMDU_ACC_W'(acc_q + acc_inc);
    assign vco_tick = acc_step && (acc_sum >= VCO_MOD);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= '0;
        end else if (load) begin
            acc_q <= '0;
        end else if (acc_step) begin
            acc_q <= vco_tick ? CMDU_ACC_W'(acc_sum - VCO_MOD) : acc_sum;
        end
    end

    // ****************************************
    // Postdivider and output selection
    // ****************************************
    assign k_in = (mode_q == CMDU_PRESCALE) ? p_tick : vco_tick;

    cmdu_div #(.W(CMDU_DIV_W)) u_kdiv (
        .clk      (ref_clk),
        .rstn     (rstn),
        .clr      (load),
        .tick_in  (k_in),
        .ratio    (k_q),
        .tick_out (k_tick)
    );

    always_comb begin
        out_d = 1'b0;
        if (!load) begin
            unique case (mode_q)
                CMDU_DIRECT:   out_d = 1'b1;
                CMDU_PRESCALE: out_d = k_tick;
                CMDU_PLL:      out_d = k_tick;
                CMDU_BASE:     out_d = k_tick;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    assign processor_clock_en  = out_q;
    assign system_bus_clock_en = out_q;

    // ****************************************
    // Switching state machine
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= CMDU_ST_RUN;
        end else begin
            unique case (state_q)
                CMDU_ST_RUN:   if (differs) state_q <= CMDU_ST_DRAIN;
                CMDU_ST_DRAIN: if (out_d) state_q <= CMDU_ST_LOAD;
                CMDU_ST_LOAD:  state_q <= CMDU_ST_RUN;
                default:       state_q <= CMDU_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= CMDU_RST_MODE;
            p_q    <= CMDU_RST_P;
            n_q    <= CMDU_RST_N;
            k_q    <= CMDU_RST_K;
        end else if (load) begin
            mode_q <= mode_req;
            p_q    <= p_factor;
            n_q    <= n_factor;
            k_q    <= k_factor;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            active_mode <= CMDU_RST_MODE;
            switch_busy <= 1'b0;
        end else begin
            active_mode <= load ? mode_req : mode_q;
            switch_busy <= differs || (state_q != CMDU_ST_RUN);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_mode_taken: assert property (@(posedge ref_clk) disable iff (!rstn)
        load |=> (active_mode == $past(mode_req)) && (mode_q == $past(mode_req)))
        else $error("mode not taken at load");

    a_direct_every: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == CMDU_ST_RUN && mode_q == CMDU_DIRECT) |=> processor_clock_en)
        else $error("direct mode missed a cycle");

    a_prescale_out: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!load && mode_q == CMDU_PRESCALE) |=> (processor_clock_en == $past(p_tick && k_tick)))
        else $error("prescaler output wrong");

    a_pll_out: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!load && mode_q == CMDU_PLL) |=> (processor_clock_en == $past(vco_tick && k_tick)))
        else $error("pll output wrong");

    a_base_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode_q == CMDU_BASE && processor_clock_en) |-> system_bus_clock_en && $past(vco_tick))
        else $error("base mode output wrong");

    a_switch_seq: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == CMDU_ST_DRAIN && out_d) |=> load ##1 (state_q == CMDU_ST_RUN))
        else $error("switch sequence broken");

    a_safe_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
        load |-> $past(out_d) ##1 !processor_clock_en)
        else $error("source changed off a pulse boundary");

    a_drain_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == CMDU_ST_DRAIN && !out_d) |=> (state_q == CMDU_ST_DRAIN))
        else $error("drain left before an output pulse");

    a_load_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        load |=> !processor_clock_en && (acc_q == '0))
        else $error("pulse or stale vco phase after load");

    a_sys_equal: assert property (@(posedge ref_clk) disable iff (!rstn)
        system_bus_clock_en == processor_clock_en)
        else $error("system bus enable differs from processor enable");

    a_vco_spaced: assert property (@(posedge ref_clk) disable iff (!rstn)
        vco_tick |=> !vco_tick)
        else $error("vco ticks in two adjacent cycles");

    a_busy_switch: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q != CMDU_ST_RUN) |=> switch_busy)
        else $error("busy low during a switch");

    a_run_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == CMDU_ST_RUN && !differs) |=> !switch_busy)
        else $error("busy high with nothing pending");

endmodule

`default_nettype wire

// File: cmdu_bench.sv
/*
 * Self-checking bench of the clock mode divider unit: all modes, corner
 * factors and random mode changes, with measured output periods.
 * Assumes the design checks its own timing relations with embedded assertions.
 */
`timescale 1ns/10ps
`default_nettype none

module cmdu_bench
    import cmdu_pkg::*;
;
    logic                  ref_clk;
    logic                  rstn;
    cmdu_mode_t            mode_req;
    logic [CMDU_DIV_W-1:0] p_factor;
    logic [CMDU_DIV_W-1:0] n_factor;
    logic [CMDU_DIV_W-1:0] k_factor;
    logic                  proc_en;
    logic                  sys_en;
    cmdu_mode_t            act_mode;
    logic                  busy;
    int                    n_errors;
    int                    num_checks;
    logic [31:0]           rnd;

    cmdu_top #(
        .VCO_DIV  (CMDU_VCO_DIV),
        .BASE_INC (CMDU_BASE_INC)
    ) u_cmdu_top (
        .ref_clk             (ref_clk),
        .rstn                (rstn),
        .mode_req            (mode_req),
        .p_factor            (p_factor),
        .n_factor            (n_factor),
        .k_factor            (k_factor),
        .processor_clock_en  (proc_en),
        .system_bus_clock_en (sys_en),
        .active_mode         (act_mode),
        .switch_busy         (busy)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic int exp_period(input cmdu_mode_t m, input logic [3:0] p, input logic [3:0] n,
                                      input logic [3:0] k);
        int pp;
        int kk;
        pp = (p == 4'h0) ? 1 : int'(p);
        kk = (k == 4'h0) ? 1 : int'(k);
        case (m)
            CMDU_PRESCALE: return pp * kk;
            CMDU_PLL:      return (pp * CMDU_VCO_DIV / int'(n)) * kk;
            CMDU_BASE:     return (CMDU_VCO_DIV / CMDU_BASE_INC) * kk;
            default:       return 1;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cycles up to and including the next output pulse
    task automatic gap(output int c);
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (proc_en !== 1'b1 && c < 1100);
    endtask

    task automatic run_mode(input cmdu_mode_t m, input logic [3:0] p, input logic [3:0] n, input logic [3:0] k);
        int c;
        int e;
        e = exp_period(m, p, n, k);
        @(posedge ref_clk);
        mode_req <= m;
        p_factor <= p;
        n_factor <= n;
        k_factor <= k;
        repeat (2) @(negedge ref_clk);
        chk("switch_busy", 32'h1, 32'(busy));
        c = 0;
        while (busy !== 1'b0 && c < 1200) begin
            @(negedge ref_clk);
            c++;
        end
        chk("switch_busy", 32'h0, 32'(busy));
        chk("active_mode", 32'(m), 32'(act_mode));
        gap(c);
        gap(c);
        chk("period", 32'(e), 32'(c));
        gap(c);
        chk("period", 32'(e), 32'(c));
    endtask

    // ****************************************
    // Clock, watchdog and sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (rstn) begin
            chk("system_bus_clock_en", 32'(proc_en), 32'(sys_en));
        end
    end

    initial begin
        #(40 * 90000);
        n_errors++;
        print_verdict;
    end

    initial begin
        cmdu_mode_t m;
        logic [3:0] p;
        logic [3:0] n;
        logic [3:0] k;
        rstn = 1'b0;
        mode_req = CMDU_DIRECT;
        p_factor = 4'h1;
        n_factor = 4'h1;
        k_factor = 4'h1;
        n_errors = 0;
        num_checks = 0;
        rnd = 32'hA8C0AD7A;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("active_mode", 32'h0, 32'(act_mode));
        chk("processor_clock_en", 32'h1, 32'(proc_en));
        run_mode(CMDU_PRESCALE, 4'h0, 4'h1, 4'h0);
        run_mode(CMDU_PLL, 4'h1, 4'h8, 4'h1);
        run_mode(CMDU_BASE, 4'h1, 4'h1, 4'hF);
        run_mode(CMDU_PRESCALE, 4'hF, 4'h1, 4'hF);
        run_mode(CMDU_DIRECT, 4'h3, 4'h2, 4'h7);
        m = CMDU_DIRECT;
        repeat (16) begin
            rnd = lfsr(rnd);
            m = cmdu_mode_t'((rnd[1:0] == 2'(m)) ? 2'(2'(m) + 2'h1) : rnd[1:0]);
            p = rnd[5:2];
            k = rnd[9:6];
            n = 4'h1 << rnd[11:10];
            if (m == CMDU_PLL) begin
                p = 4'h1;
                k = {2'h0, rnd[7:6]};
            end
            run_mode(m, p, n, k);
        end
        print_verdict;
    end
endmodule

`default_nettype wire
